// [flash_status_defines.vh]
// Constants for the flash write-status polling controller.
// Assumes a 125 MHz ref_clk; included by the controller files.
`ifndef FLASH_STATUS_DEFINES_VH
`define FLASH_STATUS_DEFINES_VH
// Status bit positions on the flash data byte
`define BIT_DATA_POLL      7
`define BIT_PRIMARY_TOG    6
`define BIT_TIME_LIMIT     5
`define BIT_ERASE_WINDOW   3
`define BIT_SECTOR_TOG     2
// APB register offsets
`define REG_CTRL           12'h000
`define REG_ADDR           12'h004
`define REG_STATUS         12'h008
`define REG_DATA           12'h00C
`define REG_CMD            12'h010
// Control fields
`define CTRL_START         0
`define CTRL_WRITE         1
`define CTRL_CLEAR         2
// Status fields
`define ST_BUSY            0
`define ST_DONE            1
`define ST_FAIL            2
`define ST_TOGGLING        3
`define ST_WINDOW_OPEN     4
`define ST_SECTOR_TOG      5
// Reset command byte
`define CMD_RESET          8'hF0
// Bus cycle timing, in ns and clock cycles (8 ns period)
`define CLK_NS             8
`define T_STROBE_NS        80
`define T_STROBE_CYC       ((`T_STROBE_NS + `CLK_NS - 1) / `CLK_NS)
`define T_RECOVER_NS       40
`define T_RECOVER_CYC      ((`T_RECOVER_NS + `CLK_NS - 1) / `CLK_NS)
`endif

// [flash_bus_cycle.v]
// One asynchronous flash bus cycle (read or write) on chip and output/write enables.
// Assumes the pins settle within the strobe time; data input is synchronised.
`timescale 1ns/100ps
`include "flash_status_defines.vh"
module flash_bus_cycle (
	input  wire        ref_clk,
	input  wire        rstn,
	input  wire        start,
	input  wire        isWrite,
	input  wire [18:0] addrIn,
	input  wire [7:0]  wrData,
	output wire        ready,
	output reg         done_r,
	output reg  [7:0]  rdData_r,
	output reg  [18:0] flashAddr_r,
	output reg         chipEn_n_r,
	output reg         outEn_n_r,
	output reg         writeEn_n_r,
	output reg  [7:0]  dqOut_r,
	output reg         dqOe_n_r,
	input  wire [7:0]  dqIn
);
	localparam S_IDLE = 3'b001;
	localparam S_STRB = 3'b010;
	localparam S_RCVR = 3'b100;
	localparam integer STROBE_INT  = `T_STROBE_CYC;
	localparam integer RECOVER_INT = `T_RECOVER_CYC;
	localparam [7:0]   STROBE_CYC  = STROBE_INT[7:0];
	localparam [7:0]   RECOVER_CYC = RECOVER_INT[7:0];
	reg [2:0] state_r;
	reg [7:0] cnt_r;
	reg [7:0] dqMeta_r;
	reg [7:0] dqSync_r;
	reg       wr_r;
	assign ready = state_r == S_IDLE;
	always @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			dqMeta_r <= 8'h00;
			dqSync_r <= 8'h00;
		end else begin
			dqMeta_r <= dqIn;
			dqSync_r <= dqMeta_r;
		end
	end
	always @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			state_r     <= S_IDLE;
			cnt_r       <= 8'h00;
			done_r      <= 1'b0;
			rdData_r    <= 8'h00;
			flashAddr_r <= 19'h0_0000;
			chipEn_n_r  <= 1'b1;
			outEn_n_r   <= 1'b1;
			writeEn_n_r <= 1'b1;
			dqOut_r     <= 8'h00;
			dqOe_n_r    <= 1'b1;
			wr_r        <= 1'b0;
		end else begin
			done_r <= 1'b0;
			case (state_r)
			S_IDLE: begin
				if (start) begin
					wr_r        <= isWrite;
					flashAddr_r <= addrIn;
					dqOut_r     <= wrData;
					dqOe_n_r    <= ~isWrite;
					chipEn_n_r  <= 1'b0;
					// Output enable frames each read so every read counts as a toggle event
					outEn_n_r   <= isWrite; // RULE_10
					writeEn_n_r <= ~isWrite;
					cnt_r       <= STROBE_CYC;
					state_r     <= S_STRB;
				end
			end
			S_STRB: begin
				if (cnt_r == 8'h01) begin
					// Sample late; the two-stage sync adds two cycles of margin
					if (!wr_r)
						rdData_r <= dqSync_r;
					chipEn_n_r  <= 1'b1;
					outEn_n_r   <= 1'b1;
					writeEn_n_r <= 1'b1;
					cnt_r       <= RECOVER_CYC;
					state_r     <= S_RCVR;
				end else begin
					cnt_r <= cnt_r - 8'h01;
				end
			end
			S_RCVR: begin
				dqOe_n_r <= 1'b1;
				if (cnt_r == 8'h01) begin
					done_r  <= 1'b1;
					state_r <= S_IDLE;
				end else begin
					cnt_r <= cnt_r - 8'h01;
				end
			end
			default: state_r <= S_IDLE;
			endcase
		end
	end
endmodule // flash_bus_cycle

// [flash_status_poller.v]
// Host-side controller that polls flash write-operation status with the toggle method.
// Assumes an APB master on ref_clk and a parallel flash on the pin ports.
//
// Functional notes
// RULE_01: Device flips primary toggle bit per read.
// RULE_02: Toggle bit valid after final write strobe.
// RULE_03: Toggle stops when operation finishes.
// RULE_04: All-protected erase toggles about 100 us.
// RULE_05: Partly protected erase skips protected sectors.
// RULE_06: Erase-suspend stops primary toggling.
// RULE_07: Protected program toggles about 2 us.
// RULE_08: Suspend-program toggles until program completes.
// RULE_09: Sector toggle bit flips in erasing sectors.
// RULE_10: Output or chip enable delimits reads.
// RULE_11: Host starts with two consecutive full reads.
// RULE_12: Toggling with time limit: recheck, reset.
// RULE_13: Array data valid after toggling stops.
// RULE_14: Returning host restarts from double read.
// RULE_15: Time-limit flag one marks failure.
// RULE_16: Programming zero to one hits limit.
// RULE_17: Host writes reset after time-limit failure.
// RULE_18: Erase-window flag zero during acceptance window.
// RULE_19: Monitoring window optional under 50 us spacing.
// RULE_20: Chip erase has no acceptance window.
// RULE_21: Window closed ignores all but suspend.
// RULE_22: Host checks window before and after command; a write job does no status read before or after its write.
// RULE_23: Polling bit inverted until completion.
// RULE_24: Toggle state flips at read strobe end.
`timescale 1ns/100ps
`include "flash_status_defines.vh"
module flash_status_poller (
	input  wire        ref_clk,
	input  wire        rstn,
	input  wire [11:0] paddr,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [31:0] pwdata,
	output wire        pready,
	output reg  [31:0] prdata,
	output wire        pslverr,
	output wire [18:0] flashAddr,
	output wire        chipEn_n,
	output wire        outEn_n,
	output wire        writeEn_n,
	output wire [7:0]  dqOut,
	output wire        dqOe_n,
	input  wire [7:0]  dqIn
);
	localparam S_IDLE   = 7'b000_0001;
	localparam S_FIRST  = 7'b000_0010;
	localparam S_SECOND = 7'b000_0100;
	localparam S_CHECK  = 7'b000_1000;
	localparam S_RECHK  = 7'b001_0000;
	localparam S_RESET  = 7'b010_0000;
	localparam S_FINAL  = 7'b100_0000;

	reg  [6:0]  state_r;
	reg  [6:0]  state_nxt;
	reg  [18:0] addr_r;
	reg  [7:0]  wdata_r;
	reg  [7:0]  prev_r;
	reg  [7:0]  result_r;
	reg         busy_r;
	reg         done_r;
	reg         fail_r;
	reg         toggling_r;
	reg         windowOpen_r;
	reg         sectorTog_r;
	reg         reqWrite_r;
	reg         cycStart;
	reg         cycWrite;
	reg  [7:0]  cycData;
	wire        cycReady;
	wire        cycDone;
	wire [7:0]  rdData;

	function isReg;
		input [11:0] a;
		input [11:0] off;
		begin
			isReg = a == off;
		end
	endfunction

	function toggled;
		input [7:0] a;
		input [7:0] b;
		begin
			toggled = a[`BIT_PRIMARY_TOG] != b[`BIT_PRIMARY_TOG];
		end
	endfunction

	flash_bus_cycle u_cycle (
		.ref_clk     (ref_clk),
		.rstn        (rstn),
		.start       (cycStart),
		.isWrite     (cycWrite),
		.addrIn      (addr_r),
		.wrData      (cycData),
		.ready       (cycReady),
		.done_r      (cycDone),
		.rdData_r    (rdData),
		.flashAddr_r (flashAddr),
		.chipEn_n_r  (chipEn_n),
		.outEn_n_r   (outEn_n),
		.writeEn_n_r (writeEn_n),
		.dqOut_r     (dqOut),
		.dqOe_n_r    (dqOe_n),
		.dqIn        (dqIn)
	);

	// Zero-wait slave; errors on unmapped addresses
	assign pready  = 1'b1;
	wire   apbWr   = psel & penable & pwrite;
	wire   mapped  = isReg(paddr, `REG_CTRL) | isReg(paddr, `REG_ADDR) | isReg(paddr, `REG_STATUS)
	               | isReg(paddr, `REG_DATA) | isReg(paddr, `REG_CMD);
	assign pslverr = psel & penable & ~mapped;
	wire   startReq = apbWr & isReg(paddr, `REG_CTRL) & pwdata[`CTRL_START] & ~busy_r;
	wire   clearReq = apbWr & isReg(paddr, `REG_CTRL) & pwdata[`CTRL_CLEAR];
	wire   jobEnd   = cycDone & (state_r == S_RESET | state_r == S_FINAL);

	always @* begin
		prdata = 32'h0000_0000;
		if (isReg(paddr, `REG_ADDR))
			prdata = {13'h0000, addr_r};
		else if (isReg(paddr, `REG_STATUS))
			prdata = {26'h000_0000, sectorTog_r, windowOpen_r, toggling_r, fail_r, done_r, busy_r}; // RULE_19
		else if (isReg(paddr, `REG_DATA))
			prdata = {24'h00_0000, result_r};
		else if (isReg(paddr, `REG_CMD))
			prdata = {24'h00_0000, wdata_r};
	end

	// Sequencer: a fresh start without the write bit begins with the double read; a write start goes straight to S_RESET
	always @* begin
		state_nxt = state_r;
		cycStart  = 1'b0;
		cycWrite  = 1'b0;
		cycData   = wdata_r;
		case (state_r)
		S_IDLE: begin
			if (startReq & pwdata[`CTRL_WRITE])
				state_nxt = S_RESET;
			else if (startReq)
				state_nxt = S_FIRST; // RULE_14
		end
		S_FIRST: begin
			cycStart = cycReady & ~cycDone;
			if (cycDone)
				state_nxt = S_SECOND; // RULE_11
		end
		S_SECOND: begin
			cycStart = cycReady & ~cycDone;
			if (cycDone)
				state_nxt = S_CHECK; // RULE_11
		end
		S_RECHK: begin
			cycStart = cycReady & ~cycDone;
			if (cycDone)
				state_nxt = S_CHECK;
		end
		S_FINAL: begin
			cycStart = cycReady & ~cycDone;
			if (cycDone)
				state_nxt = S_IDLE; // RULE_13
		end
		S_CHECK: begin
			if (reqWrite_r)
				state_nxt = S_RESET; // RULE_12
			else if (!toggled(prev_r, result_r))
				state_nxt = S_FINAL; // RULE_13
			else if (result_r[`BIT_TIME_LIMIT])
				state_nxt = S_RECHK; // RULE_12
			else
				state_nxt = S_RECHK;
		end
		S_RESET: begin
			cycStart = cycReady & ~cycDone;
			cycWrite = 1'b1;
			// A failed job writes the reset byte, a plain write job the stored command
			cycData  = fail_r ? `CMD_RESET : wdata_r; // RULE_17
			if (cycDone)
				state_nxt = S_IDLE;
		end
		default: state_nxt = S_IDLE;
		endcase
	end

	always @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			state_r <= S_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	// Target and command byte are frozen while a job runs
	always @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			addr_r  <= 19'h0_0000;
			wdata_r <= 8'h00;
		end else begin
			if (apbWr & isReg(paddr, `REG_ADDR) & ~busy_r)
				addr_r <= pwdata[18:0];
			if (apbWr & isReg(paddr, `REG_CMD) & ~busy_r)
				wdata_r <= pwdata[7:0];
		end
	end

	// Last two status bytes feed the toggle comparison
	always @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			prev_r       <= 8'h00;
			result_r     <= 8'h00;
			windowOpen_r <= 1'b0;
			sectorTog_r  <= 1'b0;
		end else begin
			if (cycDone & ~cycWrite) begin
				prev_r   <= result_r;
				result_r <= rdData; // RULE_11
				// Erase window flag low means more sector erases are still accepted
				windowOpen_r <= ~rdData[`BIT_ERASE_WINDOW]; // RULE_22
				sectorTog_r  <= rdData[`BIT_SECTOR_TOG] != result_r[`BIT_SECTOR_TOG];
			end
		end
	end

	// Still toggling on the recheck after a time-limit sighting: job failed
	always @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			reqWrite_r <= 1'b0;
		end else begin
			if (state_r == S_RECHK & cycDone)
				reqWrite_r <= toggled(result_r, rdData) & result_r[`BIT_TIME_LIMIT]; // RULE_12
			else if (state_r != S_CHECK)
				reqWrite_r <= 1'b0;
		end
	end

	// Job flags; clear is honoured only while idle so it never races a set
	always @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			busy_r     <= 1'b0;
			done_r     <= 1'b0;
			fail_r     <= 1'b0;
			toggling_r <= 1'b0;
		end else begin
			if (startReq) begin
				busy_r <= 1'b1;
				done_r <= 1'b0;
				fail_r <= 1'b0;
			end
			if (state_r == S_CHECK)
				toggling_r <= toggled(prev_r, result_r);
			if (state_r == S_CHECK & reqWrite_r)
				fail_r <= 1'b1; // RULE_15
			if (jobEnd) begin
				busy_r <= 1'b0;
				done_r <= 1'b1; // RULE_17
			end
			if (clearReq & ~busy_r) begin
				done_r <= 1'b0;
				fail_r <= 1'b0;
			end
		end
	end
endmodule // flash_status_poller

// [flash_status_poller_assertions.sv]
// Port checker for the flash status poller.
// Assumes one clock domain, ref_clk, and async active-low rstn.
`timescale 1ns/100ps
module flash_status_poller_assertions (
	input wire        ref_clk,
	input wire        rstn,
	input wire [11:0] paddr,
	input wire        psel,
	input wire        penable,
	input wire        pready,
	input wire        pslverr,
	input wire [18:0] flashAddr,
	input wire        chipEn_n,
	input wire        outEn_n,
	input wire        writeEn_n,
	input wire        dqOe_n
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	a_zero_wait: assert property (psel && penable |-> pready)
		else $error("access phase not ready");
	a_unmapped_err: assert property (psel && penable && paddr == 12'h014 |-> pslverr)
		else $error("no error on unmapped address");
	a_status_ok: assert property (psel && penable && paddr == 12'h008 |-> !pslverr)
		else $error("error on status register");
	a_read_len: assert property ($fell(outEn_n) |-> ##9 !outEn_n ##1 outEn_n)
		else $error("read strobe length wrong");
	a_write_len: assert property ($fell(writeEn_n) |-> ##9 !writeEn_n ##1 writeEn_n)
		else $error("write strobe length wrong");
	a_strobe_gap: assert property ($rose(chipEn_n) |-> chipEn_n [*5])
		else $error("recovery gap too short");
	a_no_contend: assert property (!outEn_n |-> dqOe_n && writeEn_n)
		else $error("bus driven during read");
	a_write_drive: assert property (!writeEn_n |-> !dqOe_n && outEn_n)
		else $error("data not driven during write");
	a_addr_hold: assert property (!chipEn_n && $past(!chipEn_n) |-> $stable(flashAddr))
		else $error("address moved inside cycle");
endmodule // flash_status_poller_assertions
bind flash_status_poller flash_status_poller_assertions chk_u (.ref_clk, .rstn, .paddr, .psel, .penable,
	.pready, .pslverr, .flashAddr, .chipEn_n, .outEn_n, .writeEn_n, .dqOe_n);

// [flash_status_model.sv]
// Behavioural flash device answering status reads.
// Assumes the bench loads the length of each operation in reads.
`timescale 1ns/100ps
module flash_status_model (
	input wire [18:0] flashAddr,
	input wire        chipEn_n,
	input wire        outEn_n,
	input wire        writeEn_n,
	input wire [7:0]  dqOut,
	input wire        busyGo,
	input wire [7:0]  opReads,
	input wire        failMode,
	input wire [7:0]  arrByte,
	output wire [7:0] dqIn,
	output reg [7:0]  nReads,
	output reg [7:0]  lastCmd,
	output reg [18:0] lastAddr
);
	reg       tog;
	reg [7:0] cnt;
	reg       stuck;
	reg [7:0] lastOut;
	reg       armed;
	wire      rdOn   = !chipEn_n && !outEn_n;
	wire      wrOn   = !chipEn_n && !writeEn_n;
	wire      active = (cnt != 0) || stuck;
	// Status byte while busy: polling bit inverted, window open, both toggles
	wire [7:0] busyByte = {~arrByte[7], tog, stuck, 1'b1, 1'b0, tog, 2'b00};
	wire [7:0] val      = active ? busyByte : arrByte;
	// Unselected bus shows inverse of last byte, never a stale copy
	assign dqIn = rdOn ? val : ~lastOut;
	initial begin
		tog = 0; cnt = 0; stuck = 0; lastOut = 0; nReads = 0; lastCmd = 0; lastAddr = 0; armed = 0;
	end
	always @* if (rdOn) lastOut = val;
	always @(posedge busyGo) begin
		cnt = opReads;
		stuck = failMode;
	end
	// Reset takes the strobes from unknown to high; only a read that opened may count
	always @(posedge rdOn) armed = 1;
	// Either strobe ending a read counts as one toggle event
	always @(negedge rdOn) if (armed) begin
		nReads = nReads + 1;
		if (active) tog = ~tog;
		if (cnt != 0) cnt = cnt - 1;
	end
	always @(negedge wrOn) begin
		lastCmd = dqOut;
		lastAddr = flashAddr;
		if (dqOut == 8'hF0) begin
			stuck = 0;
			cnt = 0;
		end
	end
endmodule // flash_status_model

// [flash_status_poller_tb_top.sv]
// Self-checking bench for the flash status poller over APB.
// Assumes the behavioural flash model on the pin side.
`timescale 1ns/100ps
`include "flash_status_defines.vh"
module flash_status_poller_tb_top;
	reg        ref_clk, rstn, psel, penable, pwrite, busyGo, failMode;
	reg [11:0] paddr;
	reg [31:0] pwdata, q;
	reg [7:0]  opReads, arrByte;
	reg        e;
	wire        pready, pslverr, chipEn_n, outEn_n, writeEn_n, dqOe_n;
	wire [31:0] prdata;
	wire [18:0] flashAddr, lastAddr;
	wire [7:0]  dqOut, dqIn, nReads, lastCmd;
	integer fails, n_tests, i;
	flash_status_poller dut_u (.ref_clk, .rstn, .paddr, .psel, .penable, .pwrite, .pwdata, .pready, .prdata,
		.pslverr, .flashAddr, .chipEn_n, .outEn_n, .writeEn_n, .dqOut, .dqOe_n, .dqIn);
	flash_status_model dev_u (.flashAddr, .chipEn_n, .outEn_n, .writeEn_n, .dqOut, .busyGo, .opReads,
		.failMode, .arrByte, .dqIn, .nReads, .lastCmd, .lastAddr);
	initial begin
		ref_clk = 0;
		forever #4 ref_clk = ~ref_clk;
	end
	task close_out;
		begin
			$display("Comparisons %0d, mismatches %0d", n_tests, fails);
			if (fails == 0 && n_tests > 0) $display("Finished cleanly");
			else $display("Finished with errors");
			$finish;
		end
	endtask
	task chk(input [31:0] got, input [31:0] exp);
		begin
			n_tests = n_tests + 1;
			if (got !== exp) begin
				fails = fails + 1;
				$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
			end
		end
	endtask
	// One APB transfer; q and e hold read data and error
	task apb(input [11:0] a, input w, input [31:0] d);
		integer k;
		begin
			@(posedge ref_clk);
			paddr <= a; pwrite <= w; pwdata <= d; psel <= 1; penable <= 0;
			@(posedge ref_clk);
			penable <= 1;
			k = 0;
			do begin
				@(posedge ref_clk);
				k = k + 1;
			end while (pready !== 1'b1 && k < 50);
			q = prdata;
			e = pslverr;
			if (k >= 50) begin fails = fails + 1; close_out; end
			psel <= 0; penable <= 0;
		end
	endtask
	// Loads the device, starts the poller and waits for done; q ends as STATUS
	task op(input [7:0] n, input f, input [31:0] ctl);
		integer k;
		begin
			apb(`REG_CTRL, 1, 32'h0000_0004);
			opReads <= n; failMode <= f; busyGo <= 1;
			@(posedge ref_clk);
			busyGo <= 0;
			apb(`REG_CTRL, 1, ctl);
			k = 0;
			do begin
				apb(`REG_STATUS, 0, 0);
				k = k + 1;
			end while (q[`ST_DONE] !== 1'b1 && k < 500);
			if (k >= 500) begin fails = fails + 1; close_out; end
		end
	endtask
	initial begin
		fails = 0; n_tests = 0; rstn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
		busyGo = 0; failMode = 0; opReads = 0; arrByte = 8'hA5;
		repeat (8) @(posedge ref_clk);
		rstn <= 1;
		apb(`REG_STATUS, 0, 0);
		chk(q, 0);
		apb(12'h014, 0, 0);
		chk(e, 1);
		op(0, 0, 1);
		chk(nReads, 3);
		chk(q[5:0], 6'h12);
		apb(`REG_DATA, 0, 0);
		chk(q[7:0], 8'hA5);
		// Short and long toggling runs, including a stop right after the first pair
		for (i = 1; i < 6; i = i + 2) begin
			op(i, 0, 1);
			chk(q[`ST_FAIL], 0);
			apb(`REG_DATA, 0, 0);
			chk(q[7:0], 8'hA5);
		end
		op(3, 1, 1);
		chk(q[`ST_FAIL], 1);
		chk(lastCmd, 8'hF0);
		chk(q[5:0], 6'h3E);
		apb(`REG_ADDR, 1, 32'h0007_ABCD);
		apb(`REG_CMD, 1, 32'h0000_005A);
		op(0, 0, 3);
		chk(lastCmd, 8'h5A);
		chk(lastAddr, 19'h7_ABCD);
		apb(`REG_CTRL, 1, 32'h0000_0004);
		apb(`REG_STATUS, 0, 0);
		chk(q[`ST_DONE], 0);
		close_out;
	end
endmodule // flash_status_poller_tb_top
